// >>> design/mest_top.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module mest_top
  import mest_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              mod_active,
  input  wire logic              carrier_tick,
  output logic                   clamp_closed,
  output logic                   drv_on_mod_rail,
  output logic                   drv_mod_resistance,
  output logic                   drv_stopped
);

  //////////////////////////////////////////////////////////////////////////////
  // timing fields

  logic [FIELD_W-1:0] clamp_release_delay_ff;
  logic [FIELD_W-1:0] modulation_start_delay_ff;
  logic [FIELD_W-1:0] first_resistance_change_delay_ff;
  logic [FIELD_W-1:0] driver_stop_delay_ff;
  logic [FIELD_W-1:0] return_to_rf_delay_ff;
  logic [FIELD_W-1:0] clamp_connect_delay_ff;
  logic [FIELD_W-1:0] second_resistance_change_delay_ff;
  logic [DATA_W-1:0]  rdata_ff;
  logic [DATA_W-1:0]  nxt_rdata;
  logic               clamp_closed_ff;
  logic               drv_on_mod_rail_ff;
  logic               drv_mod_resistance_ff;
  logic               drv_stopped_ff;
  logic               in_mod;
  logic               in_rec;

  mest_seq_if seq ();

  mest_period_counter u_counter (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .mod_active   (mod_active),
    .carrier_tick (carrier_tick),
    .seq          (seq.counter)
  );

  function automatic logic hit(input mest_phase_t ph, input mest_phase_t want,
                               input logic [FIELD_W-1:0] cnt,
                               input logic [FIELD_W-1:0] field);
    hit = (ph == want) && (cnt == field);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register writes; reserved nibbles are not stored, so they read zero

  function automatic logic wr_sel(input logic              wr,
                                  input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] ofs);
    wr_sel = wr && (addr == ofs);
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clamp_release_delay_ff <= FIELD_RST;
    end else if (wr_sel(reg_wr, reg_addr, OFS_CLAMP_RELEASE_TIME)) begin
      clamp_release_delay_ff <= reg_wdata[3:0];
    end
  end

  // start and first resistance share one byte and always move together
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      modulation_start_delay_ff        <= FIELD_RST;
      first_resistance_change_delay_ff <= FIELD_RST;
    end else if (wr_sel(reg_wr, reg_addr, OFS_SUPPLY_SWITCH_TIME)) begin
      modulation_start_delay_ff        <= reg_wdata[7:4];
      first_resistance_change_delay_ff <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      driver_stop_delay_ff  <= FIELD_RST;
      return_to_rf_delay_ff <= FIELD_RST;
    end else if (wr_sel(reg_wr, reg_addr, OFS_DRIVER_STOP_TIME)) begin
      driver_stop_delay_ff  <= reg_wdata[7:4];
      return_to_rf_delay_ff <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clamp_connect_delay_ff <= FIELD_RST;
    end else if (wr_sel(reg_wr, reg_addr, OFS_CLAMP_CONNECT_TIME)) begin
      clamp_connect_delay_ff <= reg_wdata[3:0];
    end
  end

  // a field written mid-period acts at once, so a match already passed is lost
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      second_resistance_change_delay_ff <= FIELD_RST;
    end else if (wr_sel(reg_wr, reg_addr, OFS_DRIVING_RES_TIME)) begin
      second_resistance_change_delay_ff <= reg_wdata[7:4];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register reads: data valid only in the cycle after the strobe

  always_comb begin
    nxt_rdata = READ_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CLAMP_RELEASE_TIME: nxt_rdata = {4'h0, clamp_release_delay_ff};
        OFS_SUPPLY_SWITCH_TIME:
          nxt_rdata = {modulation_start_delay_ff, first_resistance_change_delay_ff};
        OFS_DRIVER_STOP_TIME:   nxt_rdata = {driver_stop_delay_ff, return_to_rf_delay_ff};
        OFS_CLAMP_CONNECT_TIME: nxt_rdata = {4'h0, clamp_connect_delay_ff};
        OFS_DRIVING_RES_TIME:   nxt_rdata = {second_resistance_change_delay_ff, 4'h0};
        // status is read-only; a write to its offset lands nowhere
        OFS_SEQ_STATUS: begin
          nxt_rdata[STAT_MODULATE] = in_mod;
          nxt_rdata[STAT_RECOVER]  = in_rec;
          nxt_rdata[STAT_CLAMP]    = clamp_closed_ff;
          nxt_rdata[STAT_MOD_RAIL] = drv_on_mod_rail_ff;
          nxt_rdata[STAT_MOD_RES]  = drv_mod_resistance_ff;
          nxt_rdata[STAT_DRV_STOP] = drv_stopped_ff;
        end
        default: nxt_rdata = READ_ZERO;
      endcase
    end
  end

  // reads have no side effects, so software may poll the status freely
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= READ_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // phase decode shared by the status view and the stop release
  assign in_mod = (seq.phase == MEST_MODULATE);
  assign in_rec = (seq.phase == MEST_RECOVER);

  //////////////////////////////////////////////////////////////////////////////
  // driver controls; open clamp while idle is unsafe, so it closes at reset

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clamp_closed_ff <= 1'b1;
    end else if (hit(seq.phase, MEST_MODULATE, seq.cnt, clamp_release_delay_ff)) begin
      clamp_closed_ff <= 1'b0;
    end else if (hit(seq.phase, MEST_RECOVER, seq.cnt, clamp_connect_delay_ff)) begin
      clamp_closed_ff <= 1'b1;
    end
  end

  // a start time above the release time would drive the open rail late; the
  // host keeps it in order, the logic just follows the fields
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drv_on_mod_rail_ff <= 1'b0;
    end else if (hit(seq.phase, MEST_MODULATE, seq.cnt, modulation_start_delay_ff)) begin
      drv_on_mod_rail_ff <= 1'b1;
    end else if (hit(seq.phase, MEST_RECOVER, seq.cnt, return_to_rf_delay_ff)) begin
      drv_on_mod_rail_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drv_mod_resistance_ff <= 1'b0;
    end else if (hit(seq.phase, MEST_MODULATE, seq.cnt,
                     first_resistance_change_delay_ff)) begin
      drv_mod_resistance_ff <= 1'b1;
    end else if (hit(seq.phase, MEST_RECOVER, seq.cnt,
                     second_resistance_change_delay_ff)) begin
      drv_mod_resistance_ff <= 1'b0;
    end
  end

  // the stop lasts only for the modulation period itself
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drv_stopped_ff <= 1'b0;
    end else if (hit(seq.phase, MEST_MODULATE, seq.cnt, driver_stop_delay_ff)) begin
      drv_stopped_ff <= 1'b1;
    end else if (!in_mod) begin
      drv_stopped_ff <= 1'b0;
    end
  end

  assign reg_rdata          = rdata_ff;
  assign clamp_closed       = clamp_closed_ff;
  assign drv_on_mod_rail    = drv_on_mod_rail_ff;
  assign drv_mod_resistance = drv_mod_resistance_ff;
  assign drv_stopped        = drv_stopped_ff;

endmodule // mest_top
`default_nettype wire

// >>> design/mest_pkg.sv
`default_nettype none
package mest_pkg;

  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned FIELD_W   = 4;

  localparam logic [7:0] OFS_CLAMP_RELEASE_TIME = 8'h34;
  localparam logic [7:0] OFS_SUPPLY_SWITCH_TIME = 8'h35;
  localparam logic [7:0] OFS_DRIVER_STOP_TIME   = 8'h36;
  localparam logic [7:0] OFS_CLAMP_CONNECT_TIME = 8'h37;
  localparam logic [7:0] OFS_DRIVING_RES_TIME   = 8'h38;
  localparam logic [7:0] OFS_SEQ_STATUS         = 8'h3F;

  localparam logic [3:0] FIELD_RST = 4'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [3:0] CNT_MAX   = 4'hF;

  // status register bit positions
  localparam int unsigned STAT_MODULATE = 0;
  localparam int unsigned STAT_RECOVER  = 1;
  localparam int unsigned STAT_CLAMP    = 2;
  localparam int unsigned STAT_MOD_RAIL = 3;
  localparam int unsigned STAT_MOD_RES  = 4;
  localparam int unsigned STAT_DRV_STOP = 5;

  typedef enum logic [1:0] {
    MEST_IDLE,
    MEST_MODULATE,
    MEST_RECOVER
  } mest_phase_t;

endpackage
`default_nettype wire

// >>> design/mest_seq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mest_seq_if;
  import mest_pkg::*;
  mest_phase_t        phase;
  logic [FIELD_W-1:0] cnt;

  modport counter (output phase, output cnt);
  modport user    (input phase, input cnt);
endinterface
`default_nettype wire

// >>> design/mest_period_counter.sv
`timescale 1ns/1ps
`default_nettype none
module mest_period_counter
  import mest_pkg::*;
(
  input  wire logic    ref_clk,
  input  wire logic    rst,
  input  wire logic    mod_active,
  input  wire logic    carrier_tick,
  mest_seq_if.counter  seq
);

  logic               mod_q_ff;
  mest_phase_t        phase_ff;
  logic [FIELD_W-1:0] cnt_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mod_q_ff <= 1'b0;
    end else begin
      mod_q_ff <= mod_active;
    end
  end

  // counter restarts at each edge of the modulation period
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_ff <= MEST_IDLE;
      cnt_ff   <= FIELD_RST;
    end else if (mod_active && !mod_q_ff) begin
      phase_ff <= MEST_MODULATE;
      cnt_ff   <= FIELD_RST;
    end else if (!mod_active && mod_q_ff) begin
      phase_ff <= MEST_RECOVER;
      cnt_ff   <= FIELD_RST;
    end else if (carrier_tick) begin
      if (cnt_ff != CNT_MAX) begin
        cnt_ff <= cnt_ff + 4'h1;
      end else if (phase_ff == MEST_RECOVER) begin
        // recovery ends once every 4-bit time has been passed
        phase_ff <= MEST_IDLE;
      end
    end
  end

  assign seq.phase = phase_ff;
  assign seq.cnt   = cnt_ff;

endmodule // mest_period_counter
`default_nettype wire

// >>> sim/mest_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mest_checker
  import mest_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              mod_active,
  input wire logic              carrier_tick,
  input wire logic              clamp_closed,
  input wire logic              drv_on_mod_rail,
  input wire logic              drv_mod_resistance,
  input wire logic              drv_stopped
);
  logic [7:0] rmask;
  // bits that must read zero; unmapped reads are zero throughout
  always_comb begin
    case (reg_addr)
      8'h34, 8'h37: rmask = 8'hF0;
      8'h35, 8'h36: rmask = 8'h00;
      8'h38:        rmask = 8'h0F;
      8'h3F:        rmask = 8'hC0;
      default:      rmask = 8'hFF;
    endcase
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_read_zero_bits: assert property ($past(reg_rd) |-> (reg_rdata & $past(rmask)) == 8'h00)
    else $error("reserved read bits set");
  a_reset_state: assert property (disable iff (1'b0)
    rst |=> clamp_closed && !drv_on_mod_rail && !drv_mod_resistance && !drv_stopped)
    else $error("outputs wrong after reset");
  a_release_in_mod: assert property ($fell(clamp_closed) |-> $past(mod_active, 2))
    else $error("clamp released outside modulation");
  a_rail_in_mod: assert property ($rose(drv_on_mod_rail) |-> $past(mod_active, 2))
    else $error("rail switched outside modulation");
  a_res_in_mod: assert property ($rose(drv_mod_resistance) |-> $past(mod_active, 2))
    else $error("resistance changed outside modulation");
  a_stop_clears: assert property ($fell(mod_active) |-> ##2 !drv_stopped)
    else $error("driver stop not cleared");
  a_connect_after: assert property ($rose(clamp_closed) && !$past(rst) |-> !$past(mod_active, 2))
    else $error("clamp connected inside modulation");
endmodule // mest_checker
bind mest_top mest_checker u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mod_active(mod_active), .carrier_tick(carrier_tick), .clamp_closed(clamp_closed),
  .drv_on_mod_rail(drv_on_mod_rail), .drv_mod_resistance(drv_mod_resistance),
  .drv_stopped(drv_stopped));
`default_nettype wire

// >>> sim/mest_drv_model.sv
`timescale 1ns/1ps
`default_nettype none
module mest_drv_model (
  input  wire logic ref_clk,
  input  wire logic mod_active,
  output logic      carrier_tick
);
  logic [1:0] ph_ff = 2'h0;
  logic       mod_q_ff = 1'b0;
  logic       tick_ff = 1'b0;
  // carrier runs free; its phase restarts on every modulation edge, so ticks fall every 4 cycles
  always @(posedge ref_clk) begin
    mod_q_ff <= mod_active;
    ph_ff <= (mod_active != mod_q_ff) ? 2'h1 : ph_ff + 2'h1;
    tick_ff <= (mod_active == mod_q_ff) && (ph_ff == 2'h3);
  end
  assign carrier_tick = tick_ff;
endmodule // mest_drv_model
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mest_pkg::*;
  logic       ref_clk, rst, reg_wr, reg_rd, mod_active, carrier_tick;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       clamp_closed, drv_on_mod_rail, drv_mod_resistance, drv_stopped;
  int         fail_count = 0;
  int         compares = 0;
  mest_top DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_active(mod_active),
    .carrier_tick(carrier_tick), .clamp_closed(clamp_closed), .drv_on_mod_rail(drv_on_mod_rail),
    .drv_mod_resistance(drv_mod_resistance), .drv_stopped(drv_stopped));
  mest_drv_model PM (.ref_clk(ref_clk), .mod_active(mod_active), .carrier_tick(carrier_tick));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge ref_clk);
  endtask
  // edge is launched on a carrier tick so no tick coincides with the phase start
  task automatic run(input logic m);
    int         n;
    logic [3:0] e;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (carrier_tick !== 1'b1 && n < 99);
    if (n >= 99) fail_count++;
    if (n >= 99) stop_test();
    mod_active <= m;
    // count k is reached 4*k cycles after the phase edge; its output moves one edge later
    for (int c = 0; c < 30; c++) begin
      @(posedge ref_clk);
      e = m ? {c < 13, c >= 5, c >= 1, c >= 21} : {c >= 17, c < 9, c < 5, c < 1};
      #1 chk({4'h0, clamp_closed, drv_on_mod_rail, drv_mod_resistance, drv_stopped}, {4'h0, e});
    end
    @(posedge ref_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    mod_active = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 8'h34; a <= 8'h38; a++) rd(8'(a), 8'h00);
    rd(OFS_SEQ_STATUS, 8'h04);
    wr(8'h34, 8'h0F);
    wr(8'h37, 8'h0F);
    wr(8'h38, 8'hF0);
    wr(8'h40, 8'hFF);
    rd(8'h34, 8'h0F);
    rd(8'h37, 8'h0F);
    rd(8'h38, 8'hF0);
    rd(8'h40, 8'h00);
    wr(8'h34, 8'h03);
    wr(8'h35, 8'h10);
    wr(8'h36, 8'h52);
    wr(8'h37, 8'h04);
    wr(8'h38, 8'h10);
    rd(8'h35, 8'h10);
    rd(8'h36, 8'h52);
    run(1'b1);
    rd(OFS_SEQ_STATUS, 8'h39);
    run(1'b0);
    repeat (40) @(posedge ref_clk);
    rd(OFS_SEQ_STATUS, 8'h04);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h36, 8'h00);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
